/* File: hdl/clk_consts.svh */
`ifndef CLK_CONSTS_SVH
`define CLK_CONSTS_SVH
// Contract
// R01: three sources: fast internal 24.5 MHz, slow internal 80 kHz, external pin.
// R02: selected source passes a power-of-two divider, 1 up to 128.
// R03: after reset, fast oscillator selected, divider set to divide by 8.
// R04: fast oscillator turns on by itself whenever any function requests it.
// R05: 8-bit trim sets fast period; all zeros fastest, all ones slowest.
// R06: trim comes out of reset holding the factory calibrated value.
// R07: slow oscillator has own output divider by 1, 2, 4 or 8.
// R08: slow oscillator has a coarse frequency adjust field.
// R09: in capture mode each slow oscillator rising edge triggers a timer capture.
// R10: each capture copies the 16-bit timer count into the reload pair.
// R11: external pin keeps clocking peripherals while an internal oscillator runs.
// R12: external pin is resynchronised to system clock when not selected.
// R13: external pin becomes system clock only for source code 01b.
// R14: source may change on the fly; software picks only settled sources.
// R15: a new divider setting is accepted at any time.
// R16: internal oscillators usable right after the write enabling them.
// R17: software checks the external clock is present before selecting it.
// R18: software skips the external pin in the crossbar, digital input.
// R19: divider field value n divides by two to the n.
// R20: slow divider select 00 by 8, 01 by 4, 10 by 2, 11 by 1.
// R21: slow ready sets once stable; clears only on reset or divider change.
// R22: slow oscillator forced on whenever the watchdog is active.
// R23: source or divider switching never makes runt system clock pulses; at divide by 1 a source switch can tick next cycle.

// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_KHZ         125000
`define HF_NOM_KHZ      24500
`define LF_NOM_KHZ      80
`define HF_NOM_CYC      (`CLK_KHZ / `HF_NOM_KHZ)
`define HF_PER_MIN      (`HF_NOM_CYC - 2)
`define HF_TRIM_SHIFT   6
`define LF_NOM_CYC      (`CLK_KHZ / `LF_NOM_KHZ)
`define LF_STEP_CYC     (`LF_NOM_CYC / 32)
`define LF_PER_MIN      (`LF_NOM_CYC - 8 * `LF_STEP_CYC)
`define LF_SETTLE_TICKS 3'h4

// ----------------------------------------
// offsets, fields, reset values
// ----------------------------------------
`define ADDR_HF_TRIM    8'hC7
`define ADDR_SLOW_CTRL  8'hB1
`define ADDR_CLK_SEL    8'hA9
`define SLOW_EN_BIT     7
`define SLOW_RDY_BIT    6
`define SLOW_ADJ_LSB    2
`define CLK_DIV_LSB     4
`define SYS_DIV_RESET   3'h3
`define SLOW_ADJ_RESET  4'h0
`define SLOW_DIV_RESET  2'h0
`endif

/* File: hdl/clk_pkg.sv */
package clk_pkg;
    typedef enum logic [1:0] {
        SRC_FAST  = 2'h0,
        SRC_EXT   = 2'h1,
        SRC_SLOW  = 2'h2,
        SRC_SPARE = 2'h3
    } src_t;

    typedef enum logic [2:0] {
        LF_OFF    = 3'h1,
        LF_SETTLE = 3'h2,
        LF_READY  = 3'h4
    } lf_state_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } reg_req_t;

    typedef struct packed {
        logic        load;
        logic [15:0] value;
    } cap_t;

    typedef struct packed {
        logic [7:0]  trim;
        logic        trim_loaded;
        logic        lf_en;
        logic [3:0]  lf_adj;
        logic [1:0]  lf_div;
        logic [2:0]  sys_div;
        src_t        src_sel;
        src_t        act_src;
        lf_state_t   lf_st;
        logic [2:0]  settle;
        logic [1:0]  ext_sync;
        logic        ext_prev;
        logic [7:0]  rdata;
        logic        sys_en;
        logic        ext_en;
        logic        hf_on;
        logic        lf_on;
        cap_t        cap;
    } core_t;
endpackage : clk_pkg

/* File: hdl/osc_tick.sv */
// oscillator model: one enable pulse every period cycles while running
module osc_tick #(
    parameter int PW = 16
) (
    input  wire logic          clk,    // system clock
    input  wire logic          nrst,   // async reset, active low
    input  wire logic          en,     // oscillator running
    input  wire logic [PW-1:0] period, // cycles per oscillator period
    output logic               tick    // one-cycle oscillator edge
);
    typedef struct packed {
        logic [PW-1:0] count;
    } tick_state_t;

    tick_state_t s;
    tick_state_t n;

    // a stopped oscillator restarts a full period later, never mid-period
    always_comb begin
        n = s;
        tick = en && (s.count >= period - PW'(1));
        if (!en || tick) begin
            n.count = '0;
        end else begin
            n.count = s.count + PW'(1);
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end
endmodule : osc_tick

/* File: hdl/pow2_div.sv */
// divide a tick stream by two to the sel; sel taken only at wrap
module pow2_div #(
    parameter int              SEL_W     = 3,
    parameter logic [SEL_W-1:0] RESET_SEL = '0
) (
    input  wire logic             clk,    // system clock
    input  wire logic             nrst,   // async reset, active low
    input  wire logic             tick,   // input ticks
    input  wire logic [SEL_W-1:0] sel_in, // requested divide exponent
    output logic                  out     // divided tick
);
    localparam int CW = (1 << SEL_W) - 1;

    typedef struct packed {
        logic [CW-1:0]    count;
        logic [SEL_W-1:0] sel;
    } div_state_t;

    div_state_t    s;
    div_state_t    n;
    logic [CW-1:0] term;

    // new factor only at a wrap, so no output period is ever cut short
    always_comb begin
        n = s;
        term = CW'(~({CW{1'b1}} << s.sel)); // see R19
        out = tick && (s.count == term);
        if (tick) begin
            n.count = out ? '0 : s.count + CW'(1);
        end
        if (out) begin
            n.sel = sel_in; // see R23
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s <= '{count: '0, sel: RESET_SEL};
        end else begin
            s <= n;
        end
    end

    count_bound_a: assert property (@(posedge clk) disable iff (!nrst) // see R19
        s.count <= term) else $error("divider count beyond terminal");
    sel_latch_a: assert property (@(posedge clk) disable iff (!nrst) // see R23
        out |=> s.sel == $past(sel_in)) else $error("divider factor not taken at wrap");
endmodule : pow2_div

/* File: hdl/clock_select_divide.sv */
`include "clk_consts.svh"

// system clock source selection and post divider, modelled on one clock:
// every oscillator and the system clock are one-cycle enable pulses
module clock_select_divide
    import clk_pkg::*;
(
    input  wire logic        CLOCK,             // 125 MHz clock
    input  wire logic        NRST,              // async reset, active low
    input  wire reg_req_t    REG_REQ,           // register access
    output logic [7:0]       RDATA,             // read data, cycle after read
    input  wire logic [7:0]  HF_TRIM_FACTORY,   // factory trim value
    input  wire logic        FAST_OSC_REQ,      // fast oscillator request
    input  wire logic        WDT_ACTIVE,        // watchdog running
    input  wire logic        EXT_CLK_PIN,       // external clock pin
    input  wire logic [15:0] TIMER3_COUNT,      // timer three count
    input  wire logic        TIMER3_LF_CAPTURE, // timer three capture mode
    output logic             SYS_CLK_EN,        // system clock tick
    output logic             EXT_CLK_EN,        // resynced external tick
    output logic             FAST_OSC_ON,       // fast oscillator running
    output logic             SLOW_OSC_ON,       // slow oscillator running
    output cap_t             CAPTURE            // reload pair load
);
    // ----------------------------------------
    // state and oscillator models
    // ----------------------------------------
    core_t       s;
    core_t       n;
    logic        hf_tick;
    logic        lf_raw;
    logic        lf_out;
    logic        src_tick;
    logic        sys_tick;
    logic        ext_edge;
    logic        src_live;
    logic        wr_slow;
    logic [15:0] hf_per;
    logic [15:0] lf_per;

    // trim steps the fast period; larger code is slower
    assign hf_per = 16'(`HF_PER_MIN) + 16'(s.trim >> `HF_TRIM_SHIFT); // see R05
    // adjust steps the slow period coarsely
    assign lf_per = 16'(`LF_PER_MIN) + 16'(s.lf_adj) * 16'(`LF_STEP_CYC); // see R08

    // fast internal oscillator, about 24.5 MHz at factory trim
    osc_tick #(.PW(16)) fast_osc (
        .clk    (CLOCK),
        .nrst   (NRST),
        .en     (s.hf_on),
        .period (hf_per),
        .tick   (hf_tick)
    ); // see R01

    // slow internal oscillator, about 80 kHz at adjust 8
    osc_tick #(.PW(16)) slow_osc (
        .clk    (CLOCK),
        .nrst   (NRST),
        .en     (s.lf_on),
        .period (lf_per),
        .tick   (lf_raw)
    ); // see R01

    // slow output divider: 00 by 8 down to 11 by 1
    pow2_div #(.SEL_W(2), .RESET_SEL(2'h3)) slow_div (
        .clk    (CLOCK),
        .nrst   (NRST),
        .tick   (lf_raw),
        .sel_in (~s.lf_div),
        .out    (lf_out)
    ); // see R07 see R20

    // system post divider, two to the field value
    pow2_div #(.SEL_W(3), .RESET_SEL(`SYS_DIV_RESET)) sys_div (
        .clk    (CLOCK),
        .nrst   (NRST),
        .tick   (src_tick),
        .sel_in (s.sys_div),
        .out    (sys_tick)
    ); // see R02 see R15

    // ----------------------------------------
    // source mux
    // ----------------------------------------
    // edge from the second sync stage only; first stage feeds nothing else
    assign ext_edge = s.ext_sync[1] & ~s.ext_prev; // see R12
    // a disabled slow source would freeze the boundary, so switch at once
    assign src_live = (s.act_src != SRC_SLOW) || s.lf_on;
    assign wr_slow = REG_REQ.wr && (REG_REQ.addr == `ADDR_SLOW_CTRL);

    always_comb begin
        case (s.act_src)
            SRC_EXT:  src_tick = ext_edge; // see R13
            SRC_SLOW: src_tick = lf_out;
            default:  src_tick = hf_tick;
        endcase
    end

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        n = s;
        n.ext_sync = {s.ext_sync[0], EXT_CLK_PIN};
        n.ext_prev = s.ext_sync[1];
        n.ext_en = ext_edge; // see R11 see R12
        n.sys_en = sys_tick;
        // strap caught once after release, never under the async reset
        if (!s.trim_loaded) begin
            n.trim = HF_TRIM_FACTORY; // see R06
            n.trim_loaded = 1'b1;
        end
        // register writes; reserved bits are dropped
        if (REG_REQ.wr) begin
            case (REG_REQ.addr)
                `ADDR_HF_TRIM: n.trim = REG_REQ.wdata; // see R05
                `ADDR_SLOW_CTRL: begin
                    n.lf_en = REG_REQ.wdata[`SLOW_EN_BIT];
                    n.lf_adj = REG_REQ.wdata[`SLOW_ADJ_LSB +: 4];
                    n.lf_div = REG_REQ.wdata[1:0];
                end
                `ADDR_CLK_SEL: begin
                    n.sys_div = REG_REQ.wdata[`CLK_DIV_LSB +: 3]; // see R15
                    n.src_sel = src_t'(REG_REQ.wdata[1:0]); // see R14
                end
                default: ;
            endcase
        end
        // read data stands one cycle, zero otherwise
        n.rdata = 8'h00;
        if (REG_REQ.rd) begin
            case (REG_REQ.addr)
                `ADDR_HF_TRIM: n.rdata = s.trim;
                `ADDR_SLOW_CTRL: n.rdata = {s.lf_en, s.lf_st == LF_READY, s.lf_adj, s.lf_div};
                `ADDR_CLK_SEL: n.rdata = {1'b0, s.sys_div, 2'h0, s.src_sel};
                default: n.rdata = 8'h00;
            endcase
        end
        // slow ready: counts raw periods to settle, survives disable
        case (s.lf_st)
            LF_OFF: begin
                if (s.lf_on) begin
                    n.lf_st = LF_SETTLE;
                    n.settle = 3'h0;
                end
            end
            LF_SETTLE: begin
                if (!s.lf_on) begin
                    n.lf_st = LF_OFF;
                end else if (lf_raw) begin
                    if (s.settle == `LF_SETTLE_TICKS - 3'h1) begin
                        n.lf_st = LF_READY; // see R21
                    end else begin
                        n.settle = s.settle + 3'h1;
                    end
                end
            end
            LF_READY: n.lf_st = LF_READY;
            default: n.lf_st = LF_OFF;
        endcase
        // divider change restarts settling; this clear beats a same-cycle set
        if (wr_slow && (REG_REQ.wdata[1:0] != s.lf_div)) begin
            n.lf_st = s.lf_on ? LF_SETTLE : LF_OFF; // see R21
            n.settle = 3'h0;
        end
        // source changes at a system tick boundary, or at once when the active slow source is off
        if (sys_tick || !src_live) begin
            n.act_src = s.src_sel; // see R14 see R23
        end
        // no start-up wait: the enable bit runs the oscillator next cycle
        n.hf_on = FAST_OSC_REQ || (s.src_sel != SRC_EXT && s.src_sel != SRC_SLOW)
                  || (s.act_src != SRC_EXT && s.act_src != SRC_SLOW); // see R04 see R16
        n.lf_on = s.lf_en || WDT_ACTIVE; // see R22 see R16
        // timer three capture on slow output rising edge
        n.cap.load = TIMER3_LF_CAPTURE && lf_out; // see R09
        if (TIMER3_LF_CAPTURE && lf_out) begin
            n.cap.value = TIMER3_COUNT; // see R10
        end
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            s <= '{
                trim: 8'h00, trim_loaded: 1'b0, lf_en: 1'b0,
                lf_adj: `SLOW_ADJ_RESET, lf_div: `SLOW_DIV_RESET,
                sys_div: `SYS_DIV_RESET, src_sel: SRC_FAST, act_src: SRC_FAST,
                lf_st: LF_OFF, settle: 3'h0, ext_sync: 2'h0, ext_prev: 1'b0,
                rdata: 8'h00, sys_en: 1'b0, ext_en: 1'b0, hf_on: 1'b1,
                lf_on: 1'b0, cap: '0
            }; // see R03
        end else begin
            s <= n;
        end
    end

    // outputs all come from flip-flops
    assign RDATA = s.rdata;
    assign SYS_CLK_EN = s.sys_en;
    assign EXT_CLK_EN = s.ext_en;
    assign FAST_OSC_ON = s.hf_on;
    assign SLOW_OSC_ON = s.lf_on;
    assign CAPTURE = s.cap;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!NRST);

    reset_default_a: assert property ($past(!NRST) |-> // see R03
        s.sys_div == 3'h3 && s.act_src == SRC_FAST && s.hf_on)
        else $error("reset default not fast divided by 8");
    trim_factory_a: assert property ($past(!NRST) ##1 !$past(REG_REQ.wr) |-> // see R06
        s.trim == $past(HF_TRIM_FACTORY))
        else $error("trim not loaded from factory value");
    fast_request_a: assert property (FAST_OSC_REQ |=> FAST_OSC_ON) // see R04
        else $error("fast oscillator ignored request");
    wdt_slow_on_a: assert property (WDT_ACTIVE |=> SLOW_OSC_ON) // see R22
        else $error("slow oscillator off with watchdog active");
    ready_clear_a: assert property ( // see R21
        wr_slow && REG_REQ.wdata[1:0] != s.lf_div |=> s.lf_st != LF_READY)
        else $error("ready survived divider change");
    capture_copy_a: assert property (TIMER3_LF_CAPTURE && lf_out |=> // see R10
        CAPTURE.load && CAPTURE.value == $past(TIMER3_COUNT))
        else $error("capture did not copy timer count");
    // checked only on the switch itself: a pending change away from the
    // external source leaves it active until the next tick boundary
    ext_only_01_a: assert property ( // see R13
        s.act_src == SRC_EXT && $past(s.act_src) != SRC_EXT |-> $past(s.src_sel) == SRC_EXT)
        else $error("external source without code 01");
    no_runt_a: assert property (SYS_CLK_EN |=> !SYS_CLK_EN) // see R23
        else $error("back to back system ticks");
    div_write_a: assert property (REG_REQ.wr && REG_REQ.addr == `ADDR_CLK_SEL |=> // see R15
        s.sys_div == $past(REG_REQ.wdata[6:4]))
        else $error("divider write refused");
    ext_resync_a: assert property (ext_edge |=> EXT_CLK_EN) // see R12
        else $error("external edge not passed on");

    ext_sys_c: cover property (s.act_src == SRC_EXT && SYS_CLK_EN);
    slow_sys_c: cover property (s.act_src == SRC_SLOW && SYS_CLK_EN);
    capture_c: cover property (CAPTURE.load);
    ready_c: cover property (s.lf_st == LF_READY);
endmodule : clock_select_divide

/* File: testbench/ext_clk_model.sv */
// ----------------------------------------
// external cmos clock source at the pin
// ----------------------------------------
module ext_clk_model (
    input  wire logic       clk,  // system clock, pin kept in step with it
    input  wire logic       nrst, // async reset, active low
    input  wire logic       en,   // source present
    input  wire logic [7:0] half, // cycles per half period
    output logic            pin   // external clock pin level
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] cnt;

    // square wave while present; stands low when absent so a dead
    // source never looks like a stuck-high clock; the pin is a plain
    // digital input level, never routed through the crossbar
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt <= 8'h00;
            pin <= 1'h0;
        end else if (!en) begin
            cnt <= 8'h00;
            pin <= 1'h0;
        end else if (cnt == half - 8'h01) begin
            cnt <= 8'h00;
            pin <= ~pin;
        end else begin
            cnt <= cnt + 8'h01;
        end
    end
endmodule : ext_clk_model

/* File: testbench/tb_top.sv */
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import clk_pkg::*;

    logic        clock = 1'h0;
    logic        nrst = 1'h0;
    reg_req_t    req = '0;
    logic [7:0]  rdata;
    logic        fast_req = 1'h0;
    logic        wdt = 1'h0;
    logic        ext_en = 1'h0;
    logic        pin;
    logic [15:0] t3_count = 16'h0000;
    logic        t3_cap = 1'h0;
    logic        sys_en, ext_tick, fast_on, slow_on;
    cap_t        cap;
    int          failures = 0;
    int          n_compared = 0;
    int          cycles = 0;
    int          gap = 1000;
    int          n;
    logic [15:0] v1;

    always #4 clock = ~clock;

    clock_select_divide i_dut (
        .CLOCK(clock), .NRST(nrst), .REG_REQ(req), .RDATA(rdata),
        .HF_TRIM_FACTORY(8'h80), .FAST_OSC_REQ(fast_req), .WDT_ACTIVE(wdt),
        .EXT_CLK_PIN(pin), .TIMER3_COUNT(t3_count), .TIMER3_LF_CAPTURE(t3_cap),
        .SYS_CLK_EN(sys_en), .EXT_CLK_EN(ext_tick), .FAST_OSC_ON(fast_on),
        .SLOW_OSC_ON(slow_on), .CAPTURE(cap)
    );

    ext_clk_model i_ext (
        .clk(clock), .nrst(nrst), .en(ext_en), .half(8'h05), .pin(pin)
    );

    // ----------------------------------------
    // reporting
    // ----------------------------------------
    task automatic report_and_stop;
        if (failures == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : report_and_stop

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask : chk

    // timer count runs free; cycle ceiling cuts a hang short
    always @(posedge clock) begin
        t3_count <= t3_count + 16'h0001;
        cycles++;
        if (cycles == 60000) begin
            failures++;
            report_and_stop();
        end
    end

    // system tick spacing never below the fastest source period
    always @(posedge clock) begin
        if (nrst && sys_en === 1'h1) begin
            chk(16'(gap < 2), 16'h0000, "short system clock period");
            gap = 0;
        end else begin
            gap++;
        end
    end

    // ----------------------------------------
    // register bus and measuring tasks
    // ----------------------------------------
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        req <= '{addr: a, wdata: d, wr: 1'h1, rd: 1'h0};
        @(posedge clock);
        req <= '{addr: a, wdata: d, wr: 1'h0, rd: 1'h0};
        // one idle edge, so the next call never reassigns req in this step
        @(posedge clock);
    endtask : wr

    // read data stand only in the cycle after the read edge
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        req <= '{addr: a, wdata: 8'h00, wr: 1'h0, rd: 1'h1};
        @(posedge clock);
        req <= '{addr: a, wdata: 8'h00, wr: 1'h0, rd: 1'h0};
        @(posedge clock);
        chk({8'h00, rdata}, {8'h00, exp}, "register read");
    endtask : rd

    function automatic logic pulse(input logic ext);
        return ext ? ext_tick : sys_en;
    endfunction : pulse

    // long limit: a new slow divide select waits for a full divide-by-8 wrap
    task automatic wait_pulse(input logic ext);
        int i;
        i = 0;
        do begin
            @(posedge clock);
            i++;
        end while (pulse(ext) !== 1'h1 && i < 15000);
    endtask : wait_pulse

    // the first pulse after a change may still close the old period
    task automatic period(input logic ext, input int exp, input string msg);
        int i;
        wait_pulse(ext);
        wait_pulse(ext);
        i = 0;
        do begin
            @(posedge clock);
            i++;
        end while (pulse(ext) !== 1'h1 && i < 5000);
        chk(16'(i), 16'(exp), msg);
    endtask : period

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (16) @(posedge clock);
        nrst <= 1'h1;
        repeat (3) @(posedge clock);
        rd(8'hA9, 8'h30);
        rd(8'hC7, 8'h80);
        rd(8'hB1, 8'h00);
        wr(8'h55, 8'hFF);
        rd(8'h55, 8'h00);
        period(1'h0, 40, "reset clock period");
        // trim fastest, then every divider code back to back
        wr(8'hC7, 8'h00);
        rd(8'hC7, 8'h00);
        for (int k = 0; k < 8; k++) begin
            wr(8'hA9, 8'(k << 4));
            period(1'h0, 3 << k, "divided period");
        end
        wr(8'hC7, 8'hC0);
        wr(8'hA9, 8'hFF);
        rd(8'hA9, 8'h73);
        period(1'h0, 768, "code 11 runs fast");
        // watchdog forces the slow oscillator on
        wdt <= 1'h1;
        repeat (3) @(posedge clock);
        chk({15'h0, slow_on}, 16'h0001, "slow forced on");
        wdt <= 1'h0;
        repeat (3) @(posedge clock);
        chk({15'h0, slow_on}, 16'h0000, "slow off");
        // external source enabled before it is selected
        ext_en <= 1'h1;
        wr(8'hA9, 8'h00);
        period(1'h1, 10, "resynced external tick");
        wr(8'hA9, 8'h11);
        period(1'h0, 20, "external system clock");
        // slow oscillator, adjust 8, divide by 1, selected at once
        wr(8'hB1, 8'hA3);
        wr(8'hA9, 8'h02);
        period(1'h0, 1562, "slow period");
        repeat (4) @(posedge clock);
        chk({15'h0, fast_on}, 16'h0000, "fast idle");
        fast_req <= 1'h1;
        repeat (3) @(posedge clock);
        chk({15'h0, fast_on}, 16'h0001, "fast requested");
        fast_req <= 1'h0;
        repeat (3124) @(posedge clock);
        rd(8'hB1, 8'hE3);
        wr(8'hB1, 8'hA2);
        rd(8'hB1, 8'hA2);
        period(1'h0, 3124, "slow divide by 2");
        // two captures one slow output period apart
        t3_cap <= 1'h1;
        for (int k = 0; k < 2; k++) begin
            n = 0;
            do begin
                @(posedge clock);
                n++;
            end while (cap.load !== 1'h1 && n < 5000);
            if (k == 0) begin
                v1 = cap.value;
            end
        end
        chk(cap.value - v1, 16'h0C34, "capture spacing");
        report_and_stop();
    end
endmodule : tb_top
